// ===== rtl/arbi_result_port.sv
// Host-facing result port of the integrating converter
`timescale 1ns/1ps
// Notes on behaviour
// - Selected only when select high and enable low; strobes ignored otherwise.
// - On-demand mode: selected low write strobe starts a new conversion.
// - Data pins driven only while selected and read strobe low.
// - Mode low converts on request; mode high converts back to back.
// - On-demand byte select picks low or high result byte.
// - On-demand high byte: sign/overrange select steers the top data bit.
// - Top data bit carries polarity, overrange, result bit 7 in the low byte, or zero in the continuous-mode high byte.
// - Busy rises when de-integration starts.
// - Busy falls when conversion finishes and result is readable.
// - Sequencing is clocked from the oscillator input.
module arbi_result_port (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic chip_select,
    input wire logic chip_enable_n,
    input wire logic write_n,
    input wire logic read_n,
    input wire logic run_mode_select,
    input wire logic sign_overrange_select,
    input wire logic byte_sel_high,
    input wire logic [15:0] sample_value,
    input wire logic sample_over_range,
    output logic top_data_bit,
    output logic [6:0] lower_data_bits,
    output logic [7:0] data_oe_n,
    output logic busy
);
    // =========================================
    // Declarations
    arbi_pkg::arbi_state_t state_reg, state_next;
    logic [15:0] count_reg, count_next;
    logic [15:0] result_reg, result_next;
    logic over_reg, over_next;
    logic busy_reg, busy_next;
    logic [1:0] ptr_reg, ptr_next;
    logic rd_prev_reg, rd_prev_next;
    logic [7:0] dout_reg, dout_next;
    logic [7:0] oe_reg, oe_next;
    logic selected;
    logic start_req;
    logic [7:0] byte_val;

    assign selected = chip_select && !chip_enable_n;
    assign start_req = run_mode_select || (selected && !write_n);

    // =========================================
    // Byte multiplexer
    arbi_byte_mux arbi_byte_mux_i (
        .result(result_reg),
        .over_range(over_reg),
        .cont_mode(run_mode_select),
        .read_ptr(ptr_reg),
        .byte_sel_high(byte_sel_high),
        .sign_overrange_select(sign_overrange_select),
        .byte_out(byte_val)
    );

    // =========================================
    // Conversion sequencer on oscillator clock
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        result_next = result_reg;
        over_next = over_reg;
        busy_next = busy_reg;
        case (state_reg)
            arbi_pkg::ARBI_IDLE: begin
                if (start_req) begin
                    state_next = arbi_pkg::ARBI_INTEG;
                    count_next = arbi_pkg::INTEG_CYCLES;
                end
            end
            arbi_pkg::ARBI_INTEG: begin
                count_next = count_reg - 16'h0001;
                if (count_reg == 16'h0001) begin
                    state_next = arbi_pkg::ARBI_DEINT;
                    count_next = arbi_pkg::DEINT_CYCLES;
                    busy_next = 1'b1;
                end
            end
            arbi_pkg::ARBI_DEINT: begin
                count_next = count_reg - 16'h0001;
                if (count_reg == 16'h0001) begin
                    state_next = arbi_pkg::ARBI_IDLE;
                    result_next = sample_value;
                    over_next = sample_over_range;
                    busy_next = 1'b0;
                end
            end
            default: begin
                state_next = arbi_pkg::ARBI_IDLE;
                busy_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= arbi_pkg::ARBI_IDLE;
            count_reg <= 16'h0000;
            result_reg <= arbi_pkg::RESULT_RST;
            over_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            result_reg <= result_next;
            over_reg <= over_next;
            busy_reg <= busy_next;
        end
    end

    // =========================================
    // Read port and continuous byte pointer
    always_comb begin
        rd_prev_next = selected && !read_n;
        ptr_next = ptr_reg;
        if (!run_mode_select) begin
            ptr_next = arbi_pkg::PTR_STATUS;
        end else if (rd_prev_reg && !(selected && !read_n)) begin
            ptr_next = (ptr_reg == arbi_pkg::PTR_LAST) ? arbi_pkg::PTR_STATUS : ptr_reg + 2'h1;
        end
        dout_next = byte_val;
        oe_next = (selected && !read_n) ? 8'h00 : arbi_pkg::OE_OFF;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_reg <= arbi_pkg::PTR_STATUS;
            rd_prev_reg <= 1'b0;
            dout_reg <= arbi_pkg::BYTE_RST;
            oe_reg <= arbi_pkg::OE_OFF;
        end else begin
            ptr_reg <= ptr_next;
            rd_prev_reg <= rd_prev_next;
            dout_reg <= dout_next;
            oe_reg <= oe_next;
        end
    end

    assign top_data_bit = dout_reg[7];
    assign lower_data_bits = dout_reg[6:0];
    assign data_oe_n = oe_reg;
    assign busy = busy_reg;

    // =========================================
    // Checks
    property p_oe_select;
        @(posedge mclk) disable iff (!rst_n)
        !(chip_select && !chip_enable_n) |=> (data_oe_n == 8'hFF);
    endproperty
    a_oe_select: assert property (p_oe_select) else $error("pins driven while unselected");

    property p_oe_read;
        @(posedge mclk) disable iff (!rst_n)
        (chip_select && !chip_enable_n && !read_n) |=> (data_oe_n == 8'h00);
    endproperty
    a_oe_read: assert property (p_oe_read) else $error("pins not driven on read");

    property p_write_start;
        @(posedge mclk) disable iff (!rst_n)
        (state_reg == arbi_pkg::ARBI_IDLE && chip_select && !chip_enable_n && !write_n)
            |=> (state_reg == arbi_pkg::ARBI_INTEG);
    endproperty
    a_write_start: assert property (p_write_start) else $error("write did not start conversion");

    property p_demand_idle;
        @(posedge mclk) disable iff (!rst_n)
        (state_reg == arbi_pkg::ARBI_IDLE && !run_mode_select && (write_n || !chip_select || chip_enable_n))
            |=> (state_reg == arbi_pkg::ARBI_IDLE);
    endproperty
    a_demand_idle: assert property (p_demand_idle) else $error("conversion without request");

    property p_cont_run;
        @(posedge mclk) disable iff (!rst_n)
        (state_reg == arbi_pkg::ARBI_IDLE && run_mode_select) |=> (state_reg == arbi_pkg::ARBI_INTEG);
    endproperty
    a_cont_run: assert property (p_cont_run) else $error("continuous mode stalled");

    property p_busy_rise;
        @(posedge mclk) disable iff (!rst_n)
        $rose(busy) |-> (state_reg == arbi_pkg::ARBI_DEINT && count_reg == arbi_pkg::DEINT_CYCLES);
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy rose outside de-integrate start");

    property p_busy_fall;
        @(posedge mclk) disable iff (!rst_n)
        $fell(busy) |-> (state_reg == arbi_pkg::ARBI_IDLE && result_reg == $past(sample_value));
    endproperty
    a_busy_fall: assert property (p_busy_fall) else $error("busy fell without result");

    property p_low_byte;
        @(posedge mclk) disable iff (!rst_n)
        (!run_mode_select && !byte_sel_high) |=> (dout_reg == $past(result_reg[7:0]));
    endproperty
    a_low_byte: assert property (p_low_byte) else $error("low byte wrong");

    property p_top_bit;
        @(posedge mclk) disable iff (!rst_n)
        (!run_mode_select && byte_sel_high && sign_overrange_select) |=> (top_data_bit == $past(over_reg));
    endproperty
    a_top_bit: assert property (p_top_bit) else $error("top bit not overrange");

    property p_ptr_wrap;
        @(posedge mclk) disable iff (!rst_n)
        (run_mode_select && ptr_reg == arbi_pkg::PTR_LAST && rd_prev_reg && read_n)
            |=> (ptr_reg == arbi_pkg::PTR_STATUS);
    endproperty
    a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap");
endmodule

// ===== common/arbi_pkg.sv
// Constants and types for the converter result bus interface
package arbi_pkg;
    // =========================================
    // Widths
    localparam int DATA_W = 8;
    localparam int MAG_W = 15;
    localparam int HI_MAG_W = 7;
    // =========================================
    // Conversion timing in oscillator cycles
    localparam logic [15:0] INTEG_CYCLES = 16'h0010;
    localparam logic [15:0] DEINT_CYCLES = 16'h0020;
    // =========================================
    // Continuous-mode read pointer positions
    localparam logic [1:0] PTR_STATUS = 2'h0;
    localparam logic [1:0] PTR_HIGH = 2'h1;
    localparam logic [1:0] PTR_LOW = 2'h2;
    localparam logic [1:0] PTR_LAST = 2'h2;
    // =========================================
    // Reset values
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [7:0] OE_OFF = 8'hFF;

    typedef enum logic [1:0] {
        ARBI_IDLE,
        ARBI_INTEG,
        ARBI_DEINT
    } arbi_state_t;
endpackage

// ===== rtl/arbi_byte_mux.sv
// Result byte selection for the converter read port
`timescale 1ns/1ps
module arbi_byte_mux (
    input wire logic [15:0] result,
    input wire logic over_range,
    input wire logic cont_mode,
    input wire logic [1:0] read_ptr,
    input wire logic byte_sel_high,
    input wire logic sign_overrange_select,
    output logic [7:0] byte_out
);
    // =========================================
    // Byte layout
    always_comb begin
        byte_out = arbi_pkg::BYTE_RST;
        if (cont_mode) begin
            case (read_ptr)
                arbi_pkg::PTR_STATUS: byte_out = {result[15], over_range, 6'h00};
                arbi_pkg::PTR_HIGH: byte_out = {1'b0, result[14:8]};
                default: byte_out = result[7:0];
            endcase
        end else if (!byte_sel_high) begin
            byte_out = result[7:0];
        end else begin
            byte_out = {(sign_overrange_select ? over_range : result[15]), result[14:8]};
        end
    end
endmodule

// ===== verification/arbi_host_model.sv
// Host processor model driving the converter strobes
`timescale 1ns/1ps
module arbi_host_model (
    input wire logic mclk,
    output logic chip_select,
    output logic chip_enable_n,
    output logic write_n,
    output logic read_n,
    input wire logic [7:0] data_oe_n,
    input wire logic top_data_bit,
    input wire logic [6:0] lower_data_bits,
    input wire logic busy
);
    initial begin
        chip_select = 1'b0;
        chip_enable_n = 1'b1;
        write_n = 1'b1;
        read_n = 1'b1;
    end
    // ==========================================
    // One strobe cycle; sel is {select level, enable active}
    task automatic strobe(input logic [1:0] sel, input logic wr, output logic [7:0] d, output logic [7:0] oe);
        @(posedge mclk);
        chip_select <= sel[1];
        chip_enable_n <= !sel[0];
        if (wr) begin
            write_n <= 1'b0;
        end else begin
            read_n <= 1'b0;
        end
        @(posedge mclk);
        write_n <= 1'b1;
        read_n <= 1'b1;
        chip_select <= 1'b0;
        chip_enable_n <= 1'b1;
        #1;
        d = {top_data_bit, lower_data_bits};
        oe = data_oe_n;
    endtask
    // ==========================================
    // Bounded wait for a busy level
    task automatic count_until(input logic lvl, output int n);
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (busy !== lvl && n < 2000);
    endtask
endmodule

// ===== verification/arbi_result_port_tb.sv
// Self-checking bench for the converter result port
`timescale 1ns/1ps
module arbi_result_port_tb;
    logic mclk, rst_n, chip_select, chip_enable_n, write_n, read_n;
    logic run_mode_select, sign_overrange_select, byte_sel_high;
    logic [15:0] sample_value;
    logic sample_over_range, top_data_bit, busy;
    logic [6:0] lower_data_bits;
    logic [7:0] data_oe_n, d, oe;
    logic [7:0] cont_exp [4] = '{8'h40, 8'h7F, 8'h01, 8'h40};
    int n, fail_count = 0, total_checks = 0;

    arbi_result_port arbi_result_port_i (.mclk, .rst_n, .chip_select, .chip_enable_n, .write_n, .read_n,
        .run_mode_select, .sign_overrange_select, .byte_sel_high, .sample_value, .sample_over_range,
        .top_data_bit, .lower_data_bits, .data_oe_n, .busy);
    arbi_host_model arbi_host_model_i (.mclk, .chip_select, .chip_enable_n, .write_n, .read_n,
        .data_oe_n, .top_data_bit, .lower_data_bits, .busy);

    // ==========================================
    // Compare and close
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        #(3000 * 100);
        fail_count++;
        end_of_test();
    end
    // ==========================================
    // Test sequence
    initial begin
        rst_n = 1'b0;
        run_mode_select = 1'b0;
        sign_overrange_select = 1'b0;
        byte_sel_high = 1'b0;
        sample_value = 16'hA5C3;
        sample_over_range = 1'b0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        check(16'(data_oe_n), 16'h00FF);
        check(16'(busy), 16'h0000);
        arbi_host_model_i.strobe(2'b01, 1'b1, d, oe);
        repeat (60) @(posedge mclk);
        #1;
        check(16'(busy), 16'h0000);
        arbi_host_model_i.strobe(2'b10, 1'b0, d, oe);
        check(16'(oe), 16'h00FF);
        arbi_host_model_i.strobe(2'b11, 1'b1, d, oe);
        arbi_host_model_i.count_until(1'b1, n);
        check(16'(n), arbi_pkg::INTEG_CYCLES);
        arbi_host_model_i.count_until(1'b0, n);
        check(16'(n), arbi_pkg::DEINT_CYCLES);
        arbi_host_model_i.strobe(2'b11, 1'b0, d, oe);
        check(16'(oe), 16'h0000);
        check(16'(d), 16'h00C3);
        @(posedge mclk);
        byte_sel_high <= 1'b1;
        arbi_host_model_i.strobe(2'b11, 1'b0, d, oe);
        check(16'(d), 16'h00A5);
        @(posedge mclk);
        sign_overrange_select <= 1'b1;
        arbi_host_model_i.strobe(2'b11, 1'b0, d, oe);
        check(16'(d), 16'h0025);
        @(posedge mclk);
        run_mode_select <= 1'b1;
        sample_value <= 16'h7F01;
        sample_over_range <= 1'b1;
        arbi_host_model_i.count_until(1'b1, n);
        check(16'(busy), 16'h0001);
        arbi_host_model_i.count_until(1'b0, n);
        check(16'(n), arbi_pkg::DEINT_CYCLES);
        for (int k = 0; k < 4; k++) begin
            arbi_host_model_i.strobe(2'b11, 1'b0, d, oe);
            check(16'(cont_exp[k]) | 16'(d & 8'h00) | 16'(d), 16'(cont_exp[k]) | 16'(cont_exp[k]));
        end
        end_of_test();
    end
endmodule
